// >>> rtl/eeprom_master.sv
// eeprom_master: two-wire bus master that issues byte/page writes and sequential reads
// assumes one command at a time; read bytes leave through a two-entry buffer
`timescale 1ns/1ps
`include "eeprom_cfg.svh"
module eeprom_master
  import eeprom_pkg::*;
#(
  parameter int QTR_CYC = `SCL_QTR_CYC
) (
  // clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_n_i,
  // serial bus
  twowire_if.master                 bus,
  // command
  input  wire logic                 cmd_valid_i,
  output logic                      cmd_ready_o,
  input  wire logic                 cmd_read_i,
  input  wire logic [`ADDR_W-1:0]   cmd_addr_i,
  input  wire logic [2:0]           cmd_len_i,
  // write data
  input  wire logic                 wdata_valid_i,
  output logic                      wdata_ready_o,
  input  wire logic [7:0]           wdata_i,
  // read data
  output logic                      rdata_valid_o,
  input  wire logic                 rdata_ready_i,
  output logic [7:0]                rdata_o,
  // status
  output logic                      done_o,
  output logic                      nack_o
);
  mst_reg_t q, d;
  logic     tick, buf_ready, bit0;

  assign tick        = q.tick_cnt == 16'(QTR_CYC - 1);
  assign bit0        = q.st == M_BYTE && q.ph == 2'h0 && q.bitn == 4'h0;
  assign cmd_ready_o = q.st == M_IDLE;
  assign wdata_ready_o = tick && bit0 && q.load && q.tx;
  assign bus.scl     = q.scl;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe_n = q.oe_n;
  assign done_o      = q.done;
  assign nack_o      = q.nack;

  // read bytes wait here; a full buffer holds the clock low before the next byte
  pair_buf #(.W(8), .DEPTH(2)) u_rx (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (q.push),
    .in_ready_o  (buf_ready),
    .in_data_i   (q.sh),
    .out_valid_o (rdata_valid_o),
    .out_ready_i (rdata_ready_i),
    .out_data_o  (rdata_o)
  );

  // quarter-bit phases: set data, raise clock, sample, drop clock
  always_comb begin
    d          = q;
    d.sd1      = bus.sda;
    d.sd2      = q.sd1;
    d.done     = 1'b0;
    d.push     = 1'b0;
    d.tick_cnt = (tick || q.st == M_IDLE) ? '0 : q.tick_cnt + 16'h1;
    case (q.st)
      M_IDLE: begin
        d.scl  = 1'b1;
        d.oe_n = 1'b1;
        if (cmd_valid_i) begin
          d.sh    = {cmd_addr_i, cmd_read_i};
          d.rw    = cmd_read_i;
          d.rem   = cmd_len_i;
          d.tx    = 1'b1;
          d.first = 1'b1;
          d.load  = 1'b0;
          d.nack  = 1'b0;
          d.ph    = '0;
          d.st    = M_START;
        end
      end
      M_START: begin
        if (tick) begin
          if (q.ph == 2'h0) begin
            d.oe_n = 1'b0;
            d.ph   = 2'h1;
          end else begin
            d.scl  = 1'b0;
            d.ph   = '0;
            d.bitn = '0;
            d.st   = M_BYTE;
          end
        end
      end
      M_BYTE: begin
        if (tick) begin
          case (q.ph)
            2'h0: begin
              // stall on an empty write stream or a full read buffer
              if (bit0 && q.tx && q.load) begin
                if (wdata_valid_i) begin
                  d.sh   = wdata_i;
                  d.load = 1'b0;
                  d.oe_n = wdata_i[7];
                  d.ph   = 2'h1;
                end
              end else if (!(bit0 && !q.tx && !buf_ready)) begin
                if (q.bitn == 4'h8) begin
                  d.oe_n = q.tx || q.rem == 3'h0;
                end else begin
                  d.oe_n = q.tx ? q.sh[7] : 1'b1;
                end
                d.ph = 2'h1;
              end
            end
            2'h1: begin
              d.scl = 1'b1;
              d.ph  = 2'h2;
            end
            2'h2: begin
              if (q.bitn == 4'h8) begin
                d.ack_in = !q.sd2;
              end else begin
                d.sh   = {q.sh[6:0], q.sd2};
                d.push = !q.tx && q.bitn == 4'h7;
              end
              d.ph = 2'h3;
            end
            default: begin
              d.scl = 1'b0;
              d.ph  = '0;
              if (q.bitn != 4'h8) begin
                d.bitn = q.bitn + 4'h1;
              end else begin
                d.bitn  = '0;
                d.first = 1'b0;
                if (q.tx && !q.ack_in) begin
                  d.nack = 1'b1;
                  d.st   = M_STOP;
                end else if (q.tx && q.first && q.rw) begin
                  d.tx = 1'b0;
                end else if (q.tx && q.first) begin
                  d.load = 1'b1;
                end else if (q.rem == 3'h0) begin
                  d.st = M_STOP;
                end else begin
                  d.rem  = q.rem - 3'h1;
                  d.load = q.tx;
                end
              end
            end
          endcase
        end
      end
      M_STOP: begin
        if (tick) begin
          case (q.ph)
            2'h0: begin
              d.oe_n = 1'b0;
              d.ph   = 2'h1;
            end
            2'h1: begin
              d.scl = 1'b1;
              d.ph  = 2'h2;
            end
            default: begin
              d.oe_n = 1'b1;
              d.done = 1'b1;
              d.st   = M_IDLE;
            end
          endcase
        end
      end
      default: begin
        d.st = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q      <= '0;
      q.st   <= M_IDLE;
      q.scl  <= 1'b1;
      q.oe_n <= 1'b1;
      q.sd1  <= 1'b1;
      q.sd2  <= 1'b1;
    end else begin
      q <= d;
    end
  end
endmodule : eeprom_master

// >>> rtl/eeprom_cfg.svh
// eeprom_cfg.svh: sizes, bus timing and write-time constants for the serial eeprom ends
// assumes a 250 MHz reference clock on both ends
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH
`define CLK_NS        4
`define MEM_WORDS     128
`define ADDR_W        7
`define PAGE_BYTES    4
`define TW_NS         10000000
`define TW_CYC        (`TW_NS / `CLK_NS)
`define SCL_PERIOD_NS 2560
`define SCL_QTR_CYC   (`SCL_PERIOD_NS / (4 * `CLK_NS))
`define MEM_INIT      8'hff
`endif

// >>> rtl/eeprom_pkg.sv
// eeprom_pkg: state encodings and state records of both bus ends
// assumes eeprom_cfg.svh is on the include path
`include "eeprom_cfg.svh"
package eeprom_pkg;
  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_ACK, D_WR, D_RD, D_RACK, D_BUSY} dev_state_t;
  typedef enum logic [1:0] {M_IDLE, M_START, M_BYTE, M_STOP} mst_state_t;

  typedef struct packed {
    logic                                  sc1, sc2, scp, sd1, sd2, sdp;
    logic                                  por1, por2, wp1, wp2;
    dev_state_t                            st;
    logic [3:0]                            cnt;
    logic [7:0]                            sh;
    logic [`ADDR_W-1:0]                    addr;
    logic                                  rw, wp_lat, ack_in, oe_n;
    logic [`PAGE_BYTES-1:0][7:0]           pg;
    logic [`PAGE_BYTES-1:0]                pv;
    logic [31:0]                           busy_cnt;
    logic [`MEM_WORDS-1:0][7:0]            mem;
  } dev_reg_t;

  typedef struct packed {
    mst_state_t  st;
    logic [15:0] tick_cnt;
    logic [1:0]  ph;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic [2:0]  rem;
    logic        tx, first, load, rw, ack_in;
    logic        scl, oe_n, sd1, sd2, nack, done, push;
  } mst_reg_t;
endpackage : eeprom_pkg

// >>> rtl/twowire_if.sv
// twowire_if: serial clock plus open-drain data line shared by master and eeprom
// assumes both ends release sda with oe_n high; the line idles high as with a pull-up
`timescale 1ns/1ps
interface twowire_if;
  logic scl;        // driven by the master only
  logic m_sda_o;
  logic m_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic sda;        // resolved wired-and level

  // pulled high unless some end enables a low
  assign sda = !((!m_sda_oe_n && !m_sda_o) || (!d_sda_oe_n && !d_sda_o));

  modport master (output scl, output m_sda_o, output m_sda_oe_n, input sda);
  modport device (input scl, input sda, output d_sda_o, output d_sda_oe_n);
endinterface : twowire_if

// >>> rtl/pair_buf.sv
// pair_buf: small fifo with valid/ready on both sides, default two entries
// assumes producer and consumer on ref_clk_i
`timescale 1ns/1ps
module pair_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  // fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp, rp;
    logic [PW:0]             cnt;
  } buf_t;
  buf_t q, d;
  logic push, pop;

  // full and empty come straight from the occupancy count
  assign in_ready_o  = q.cnt != (PW+1)'(DEPTH);
  assign out_valid_o = q.cnt != '0;
  assign out_data_o  = q.mem[q.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // pointers wrap at DEPTH, which need not be a power of two
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
    end
    d.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : pair_buf

// >>> rtl/eeprom_slave.sv
// eeprom_slave: two-wire slave end of a 128 x 8 non-volatile store with 4-byte page writes
// assumes scl/sda, por and write protect arrive asynchronously; everything runs on ref_clk_i
`timescale 1ns/1ps
`include "eeprom_cfg.svh"

// Overview of operation
// - store of 128 bytes, 7-bit word address
// - after start take address plus direction, acknowledge
// - acknowledge received bytes low in ninth clock
// - master acknowledges each byte it reads; eeprom_master leaves the last byte unacknowledged
// - master ends each transfer with stop
// - power-on reset ignores all commands
// - data line open drain, never driven high
// - write protect high blocks writes
// - unconnected write protect reads low
// - master owns clock; slave never starts transfers
// - start is data falling while clock high
// - nothing answered before a start
// - watch for start except while programming
// - shift data only with serial clock
// - up to four bytes per page write
// - programming cycle timed internally
// - word address advances after each byte
// - stop ends read, or starts programming after write
// - sample data on rising clock edge
// - page write increments two low address bits
// - no address acknowledge while programming
module eeprom_slave
  import eeprom_pkg::*;
#(
  parameter int WRITE_CYCLES = `TW_CYC
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // serial bus
  twowire_if.device bus,
  // user side
  input  wire logic por_i,
  input  wire logic write_protect_in_i,
  output logic      busy_o
);
  dev_reg_t q, d;
  logic     rise, fall, start, stop;

  // 2-bit page-local increment keeps the row fixed during a page write
  function automatic logic [`ADDR_W-1:0] page_inc(input logic [`ADDR_W-1:0] a);
    page_inc = {a[`ADDR_W-1:2], 2'(a[1:0] + 2'h1)};
  endfunction : page_inc

  // edges are taken from the second sync stage and its delayed copy only
  assign rise  = q.sc2 && !q.scp;
  assign fall  = !q.sc2 && q.scp;
  assign start = q.sc2 && q.scp && q.sdp && !q.sd2;
  assign stop  = q.sc2 && q.scp && !q.sdp && q.sd2;

  // only ever pull low; a one is sent by releasing the line
  assign bus.d_sda_o    = 1'b0;
  assign bus.d_sda_oe_n = q.oe_n;
  assign busy_o         = q.st == D_BUSY;

  // whole protocol engine; bus events beat the per-state decode
  always_comb begin
    d      = q;
    d.sc1  = bus.scl;
    d.sc2  = q.sc1;
    d.scp  = q.sc2;
    d.sd1  = bus.sda;
    d.sd2  = q.sd1;
    d.sdp  = q.sd2;
    d.por1 = por_i;
    d.por2 = q.por1;
    // the pin carries a default low from outside when left open
    d.wp1  = write_protect_in_i;
    d.wp2  = q.wp1;
    if (q.st == D_BUSY) begin
      // bus is not looked at at all, so polling gets no acknowledge
      d.oe_n = 1'b1;
      if (q.busy_cnt == '0) begin
        for (int i = 0; i < `PAGE_BYTES; i++) begin
          if (q.pv[i]) begin
            d.mem[{q.addr[`ADDR_W-1:2], 2'(i)}] = q.pg[i];
          end
        end
        d.pv = '0;
        d.st = D_IDLE;
      end else begin
        d.busy_cnt = q.busy_cnt - 32'h1;
      end
    end else if (q.por2) begin
      // supply not good: forget any pending page and stay silent
      d.st   = D_IDLE;
      d.oe_n = 1'b1;
      d.pv   = '0;
    end else if (start) begin
      d.st     = D_ADDR;
      d.cnt    = '0;
      d.oe_n   = 1'b1;
      d.pv     = '0;
      d.wp_lat = q.wp2;
    end else if (stop) begin
      d.oe_n = 1'b1;
      if (q.pv != '0) begin
        d.st       = D_BUSY;
        d.busy_cnt = 32'(WRITE_CYCLES - 1);
      end else begin
        d.st = D_IDLE;
      end
    end else begin
      case (q.st)
        D_ADDR: begin
          // protection is judged from start to the end of the address byte
          d.wp_lat = q.wp_lat | q.wp2;
          if (rise) begin
            d.sh  = {q.sh[6:0], q.sd2};
            d.cnt = q.cnt + 4'h1;
          end else if (fall && q.cnt == 4'h8) begin
            d.addr = q.sh[7:1];
            d.rw   = q.sh[0];
            d.oe_n = 1'b0;
            d.cnt  = '0;
            d.st   = D_ACK;
          end
        end
        D_ACK: begin
          if (fall) begin
            if (q.rw) begin
              d.sh   = q.mem[q.addr];
              d.oe_n = q.mem[q.addr][7];
              d.addr = q.addr + 7'h1;
              d.cnt  = '0;
              d.st   = D_RD;
            end else begin
              d.oe_n = 1'b1;
              d.st   = D_WR;
            end
          end
        end
        D_WR: begin
          if (rise) begin
            d.sh  = {q.sh[6:0], q.sd2};
            d.cnt = q.cnt + 4'h1;
          end else if (fall && q.cnt == 4'h8) begin
            d.cnt = '0;
            if (q.wp_lat) begin
              // protected: no latch, no acknowledge, wait for the stop
              d.st = D_IDLE;
            end else begin
              d.pg[q.addr[1:0]] = q.sh;
              d.pv[q.addr[1:0]] = 1'b1;
              d.addr = page_inc(q.addr);
              d.oe_n = 1'b0;
              d.st   = D_ACK;
            end
          end
        end
        D_RD: begin
          if (fall) begin
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == 4'h7) begin
              d.oe_n = 1'b1;                                   // master owns the ninth bit
              d.st   = D_RACK;
            end else begin
              d.sh   = {q.sh[6:0], 1'b0};
              d.oe_n = q.sh[6];
            end
          end
        end
        D_RACK: begin
          if (rise) begin
            d.ack_in = !q.sd2;
          end else if (fall) begin
            if (q.ack_in) begin
              d.sh   = q.mem[q.addr];
              d.oe_n = q.mem[q.addr][7];
              d.addr = q.addr + 7'h1;
              d.cnt  = '0;
              d.st   = D_RD;
            end else begin
              d.st = D_IDLE;                                   // no acknowledge: standby
            end
          end
        end
        default: begin
          d.oe_n = 1'b1;
        end
      endcase
    end
  end

  // sync stages reset to the idle-high bus so release makes no false start
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q      <= '0;
      q.st   <= D_IDLE;
      q.sc1  <= 1'b1;
      q.sc2  <= 1'b1;
      q.scp  <= 1'b1;
      q.sd1  <= 1'b1;
      q.sd2  <= 1'b1;
      q.sdp  <= 1'b1;
      q.oe_n <= 1'b1;
      q.mem  <= {`MEM_WORDS{`MEM_INIT}};
    end else begin
      q <= d;
    end
  end
endmodule : eeprom_slave

// >>> tb/eeprom_link_asserts.sv
// eeprom_link_asserts: timing and ownership checks on the shared two-wire link
// assumes every input is sampled on the reference clock that both ends run on
`timescale 1ns/1ps
module eeprom_link_asserts #(
  parameter int WRITE_CYCLES = 1000
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // link lines
  input wire logic scl,
  input wire logic m_sda_o,
  input wire logic m_sda_oe_n,
  input wire logic d_sda_o,
  input wire logic d_sda_oe_n,
  input wire logic sda,
  // slave status
  input wire logic busy_o,
  input wire logic por_i
);
  logic [31:0] busy_len_q;
  logic [31:0] busy_len_d;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // length of the running programming interval; a one-cycle slack allows for the stop sync
  always_comb begin
    busy_len_d = busy_o ? busy_len_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge ref_clk_i) begin
    busy_len_q <= rst_n_i ? busy_len_d : 32'h0;
  end

  open_drain_a: assert property ((d_sda_oe_n || !d_sda_o) && (m_sda_oe_n || !m_sda_o))
    else $error("a data line driver enabled a high level");
  dev_edge_low_a: assert property ($changed(d_sda_oe_n) |-> !scl)
    else $error("slave changed the data line while the clock was high");
  ack_hold_a: assert property ($fell(d_sda_oe_n) |-> !d_sda_oe_n [*8])
    else $error("slave low level shorter than a clock half");
  reset_quiet_a: assert property ($rose(rst_n_i) |-> d_sda_oe_n [*8])
    else $error("slave drove the link right after reset");
  busy_quiet_a: assert property (busy_o |-> d_sda_oe_n)
    else $error("slave answered while programming");
  por_quiet_a: assert property (por_i && $past(por_i, 3) |-> d_sda_oe_n)
    else $error("slave answered while power-on reset held");
  write_time_a: assert property ($fell(busy_o) |-> busy_len_q >= WRITE_CYCLES && busy_len_q <= WRITE_CYCLES + 1)
    else $error("programming interval length wrong");
  sda_stable_a: assert property ($rose(scl) |=> $stable(sda) [*7])
    else $error("data line moved just after a clock rise");
  scl_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("serial clock high phase too short");
  addr_ack_a: assert property ($fell(sda) && scl && !busy_o && !por_i |-> ##[200:420] !d_sda_oe_n)
    else $error("address byte not acknowledged in time");

  // main scenarios reached
  start_seen_c: cover property ($fell(sda) && scl);
  busy_seen_c: cover property ($rose(busy_o));
  busy_end_c: cover property ($fell(busy_o));
endmodule : eeprom_link_asserts

// >>> tb/serial_eeprom_128x8_slave_tb.sv
// serial_eeprom_128x8_slave_tb: master and eeprom ends joined on one link, driven from the command side
// assumes the design files and eeprom_cfg.svh are compiled first
`timescale 1ns/1ps
module serial_eeprom_128x8_slave_tb;
  localparam int WR_CYC = 1000;
  logic       ref_clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       cmd_valid = 1'b0, cmd_read = 1'b0, wdata_valid = 1'b0, rdata_ready = 1'b0;
  logic       por = 1'b0, wp = 1'b0;
  logic [6:0] cmd_addr = 7'h00, a;
  logic [2:0] cmd_len = 3'h0;
  logic [7:0] wdata = 8'h00, rdata, first_byte;
  logic       cmd_ready, wdata_ready, rdata_valid, done, nack, busy, ack_bit;
  logic [7:0] mem_m [128];
  logic [7:0] wq [8];
  logic [7:0] got_q [8];
  int         bit_n = 99, done_t = 0, err_count = 0, tests_run = 0;

  twowire_if bus ();
  always #2 ref_clk_i = ~ref_clk_i;

  eeprom_master #(.QTR_CYC(10)) eeprom_master_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus(bus), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .cmd_read_i(cmd_read), .cmd_addr_i(cmd_addr), .cmd_len_i(cmd_len), .wdata_valid_i(wdata_valid),
    .wdata_ready_o(wdata_ready), .wdata_i(wdata), .rdata_valid_o(rdata_valid), .rdata_ready_i(rdata_ready),
    .rdata_o(rdata), .done_o(done), .nack_o(nack));
  eeprom_slave #(.WRITE_CYCLES(WR_CYC)) eeprom_slave_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus(bus), .por_i(por), .write_protect_in_i(wp), .busy_o(busy));
  eeprom_link_asserts #(.WRITE_CYCLES(WR_CYC)) eeprom_link_asserts_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scl(bus.scl), .m_sda_o(bus.m_sda_o), .m_sda_oe_n(bus.m_sda_oe_n),
    .d_sda_o(bus.d_sda_o), .d_sda_oe_n(bus.d_sda_oe_n), .sda(bus.sda), .busy_o(busy), .por_i(por));

  // take the address byte and its ninth bit off the wire, msb first
  always @(negedge bus.sda) if (bus.scl === 1'b1) bit_n = 0;
  always @(posedge bus.scl) begin
    if (bit_n < 8) first_byte = {first_byte[6:0], bus.sda};
    if (bit_n == 8) ack_bit = bus.sda;
    bit_n++;
  end

  function automatic logic [6:0] page_at(input logic [6:0] base, input int i);
    return {base[6:2], base[1:0] + 2'(i)}; // row stays, low bits wrap
  endfunction : page_at

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // one command; the reader holds off for stall cycles, then takes words at random
  task automatic run(input logic rd, input logic [6:0] ad, input logic [2:0] n, input int stall);
    int k, r, t;
    logic fin;
    k = 0; r = 0; t = 0; fin = 1'b0;
    @(negedge ref_clk_i);
    cmd_valid = 1'b1; cmd_read = rd; cmd_addr = ad; cmd_len = n;
    wdata_valid = !rd; wdata = wq[0];
    @(negedge ref_clk_i);
    cmd_valid = 1'b0;
    while (!(fin && (!rd || r > n || nack === 1'b1)) && t < 20000) begin
      @(posedge ref_clk_i);
      if (wdata_ready === 1'b1 && wdata_valid === 1'b1 && k < 7) k++;
      if (rdata_valid === 1'b1 && rdata_ready === 1'b1 && r < 8) begin
        got_q[r] = rdata;
        r++;
      end
      if (done === 1'b1 && !fin) begin
        fin = 1'b1;
        done_t = t;
      end
      @(negedge ref_clk_i);
      wdata = wq[k];
      // gaps in the write stream make the master wait with the clock low
      wdata_valid = !rd && ($urandom_range(3, 0) != 0);
      rdata_ready = (t >= stall) && ($urandom_range(3, 0) != 0);
      t++;
    end
    wdata_valid = 1'b0;
    rdata_ready = 1'b0;
    check(fin, 1'b1);
    check(first_byte, {ad, rd});
  endtask : run

  task automatic wr(input logic [6:0] ad, input logic [2:0] n);
    for (int i = 0; i <= n; i++) wq[i] = 8'($urandom_range(255, 0));
    run(1'b0, ad, n, 0);
    check(nack, 1'b0);
    check(ack_bit, 1'b0);
    for (int i = 0; i <= n; i++) mem_m[page_at(ad, i)] = wq[i];
    repeat (8) @(negedge ref_clk_i);
    check(busy, 1'b1);
  endtask : wr

  task automatic idle(input int lo);
    int t;
    t = 0;
    while (busy !== 1'b0 && t < 3000) begin
      @(negedge ref_clk_i);
      t++;
    end
    check(t < 3000 && t >= lo, 1'b1);
  endtask : idle

  task automatic rd(input logic [6:0] ad, input logic [2:0] n, input int stall);
    run(1'b1, ad, n, stall);
    check(nack, 1'b0);
    for (int i = 0; i <= n; i++) check(got_q[i], mem_m[ad + 7'(i)]);
  endtask : rd

  task automatic complete_run();
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // hang guard, well past the longest expected run
  initial begin
    repeat (90000) @(posedge ref_clk_i);
    err_count++;
    complete_run();
  end

  initial begin
    foreach (mem_m[i]) mem_m[i] = 8'hff;
    repeat (3) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    void'($urandom(32'h1b99));
    @(negedge ref_clk_i);
    check(bus.scl, 1'b1);
    check(bus.sda, 1'b1);
    check(busy, 1'b0);
    check(cmd_ready, 1'b1);
    // page write from two below the row end, then poll while it programs
    a = {5'($urandom_range(31, 0)), 2'h2};
    wr(a, 3'h3);
    run(1'b1, a, 3'h0, 0);
    check(nack, 1'b1);
    check(ack_bit, 1'b1);
    idle(0);
    rd({a[6:2], 2'h0}, 3'h3, 0);
    rd(7'h7f, 3'h1, 0);
    // protected write: no data acknowledge, no programming, store unchanged
    wp = 1'b1;
    wq[0] = ~mem_m[a];
    run(1'b0, a, 3'h0, 0);
    check(nack, 1'b1);
    repeat (8) @(negedge ref_clk_i);
    check(busy, 1'b0);
    wp = 1'b0;
    rd(a, 3'h0, 0);
    // power-on reset held: the slave ignores the command
    por = 1'b1;
    run(1'b1, a, 3'h0, 0);
    check(nack, 1'b1);
    por = 1'b0;
    // random writes and read-backs
    repeat (3) begin
      a = 7'($urandom_range(127, 0));
      wr(a, 3'($urandom_range(3, 0)));
      idle(WR_CYC - 100);
      rd(a & 7'h7c, 3'($urandom_range(7, 0)), 0);
    end
    // reader stalls long enough to fill the two-entry buffer; no word may be lost
    rd(7'h7c, 3'h7, 3000);
    check(done_t > 3000, 1'b1);
    complete_run();
  end
endmodule : serial_eeprom_128x8_slave_tb
